// ==== core/wsr_pkg.sv ====
// Purpose: constants, types and helpers for the wake-up status bank
// Assumes: 8-bit register port, 20 MHz ref_clk
// Notes: offsets are byte addresses on the register port
//
// Functional notes
// [RULE_01] status bit 6 shows calibration error
// [RULE_02] status bit 5 shows calibration finished
// [RULE_03] status bit 4 shows crystal settled
// [RULE_04] status bit 3 shows crystal output level
// [RULE_05] status bit 2 records a cold start
// [RULE_06] status bit 1 latches timer timeout
// [RULE_07] status bit 0 live while counter zero
// [RULE_08] strength register holds received packet power
// [RULE_09] software subtracts 107 to get dBm
// [RULE_10] pull-in limit resets to 50, reloaded on receive
// [RULE_11] reload value is half the IF bandwidth
// [RULE_12] image-cal bit 5 enables result overwrite
// [RULE_13] frequency field selects crystal divider
// [RULE_14] power field maps to source power multiple
// [RULE_15] shutdown needs request bit and chip select
// [RULE_16] flag clear bit clears timeout and cold flags
// [RULE_17] timer counts down, times out at zero
// [RULE_18] read-only writes ignored, reserved reads zero
package wsr_pkg;
	typedef logic [9:0] wsr_addr_t;
	typedef logic [7:0] wsr_byte_t;

	localparam wsr_addr_t ADR_FLAG_CTRL = 10'h310;
	localparam wsr_addr_t ADR_STATUS    = 10'h311;
	localparam wsr_addr_t ADR_RSSI      = 10'h312;
	localparam wsr_addr_t ADR_AFC       = 10'h315;
	localparam wsr_addr_t ADR_IMG_CAL   = 10'h319;
	localparam wsr_addr_t ADR_SHUTDOWN  = 10'h322;
	localparam wsr_addr_t ADR_TMR_LO    = 10'h340;
	localparam wsr_addr_t ADR_TMR_HI    = 10'h341;
	localparam wsr_addr_t ADR_TMR_CTRL  = 10'h342;
	localparam wsr_addr_t ADR_IRQ_STAT  = 10'h343;
	localparam wsr_addr_t ADR_IRQ_MASK  = 10'h344;

	localparam int ST_CAL_ERR  = 6;
	localparam int ST_CAL_DONE = 5;
	localparam int ST_XTAL_RDY = 4;
	localparam int ST_XTAL_LVL = 3;
	localparam int ST_COLD     = 2;
	localparam int ST_TO_FLAG  = 1;
	localparam int ST_TO_LIVE  = 0;
	localparam int FC_CAL_EN   = 1;
	localparam int FC_CLEAR    = 0;
	localparam int IMG_OVWRT   = 5;
	localparam int IMG_FREQ_LO = 3;
	localparam int IMG_PWR_LO  = 0;
	localparam int SHUT_REQ    = 0;
	localparam int TC_ENABLE   = 0;
	localparam int TC_XTAL_EN  = 1;
	localparam int TC_PRESC_LO = 2;

	localparam int IRQ_W        = 4;
	localparam int IRQ_TIMEOUT  = 0;
	localparam int IRQ_PACKET   = 1;
	localparam int IRQ_CAL_DONE = 2;
	localparam int IRQ_XTAL_RDY = 3;

	localparam wsr_byte_t AFC_RESET  = 8'h32;
	localparam wsr_byte_t BYTE_ZERO  = 8'h00;

	localparam int CLK_PERIOD_NS  = 50;
	localparam int TICK_PERIOD_NS = 30520;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// prescaler ratio in 32 kHz ticks
	function automatic logic [16:0] wsr_presc_ticks(input logic [2:0] sel);
		unique case (sel)
			3'h0: wsr_presc_ticks = 17'h00001;
			3'h1: wsr_presc_ticks = 17'h00004;
			3'h2: wsr_presc_ticks = 17'h00008;
			3'h3: wsr_presc_ticks = 17'h00010;
			3'h4: wsr_presc_ticks = 17'h00080;
			3'h5: wsr_presc_ticks = 17'h00400;
			3'h6: wsr_presc_ticks = 17'h02000;
			3'h7: wsr_presc_ticks = 17'h10000;
		endcase
	endfunction
endpackage

// ==== core/wsr_timer_if.sv ====
// Purpose: control and status between register bank and wake-up timer
// Assumes: both ends on ref_clk
// Notes: live is combinational, timeout a one-cycle pulse
`timescale 1ns/1ns
interface wsr_timer_if;
	logic        enable;
	logic        load;
	logic [15:0] reload;
	logic [2:0]  presc_sel;
	logic        timeout;
	logic        live;
	logic [15:0] count;

	modport ctrl (output enable, load, reload, presc_sel,
		input timeout, live, count);
	modport tmr (input enable, load, reload, presc_sel,
		output timeout, live, count);
endinterface

// ==== core/wsr_wakeup_timer.sv ====
// Purpose: wake-up down counter with 32 kHz base and prescaler
// Assumes: base tick derived from ref_clk, not a real crystal
// Notes: counter reloads on the tick after reaching zero
`timescale 1ns/1ns
module wsr_wakeup_timer
	import wsr_pkg::*;
(
	// clock and reset
	input wire logic   ref_clk,
	input wire logic   rst,
	// timer link
	wsr_timer_if.tmr   tif
);
	localparam logic [9:0] BASE_LAST = 10'(TICK_CYCLES - 1);

	logic [9:0]  base;
	logic [16:0] presc;
	logic        base_tick;
	logic        tick;

	assign base_tick = (base == BASE_LAST);
	assign tick = base_tick &&
		(presc >= wsr_presc_ticks(tif.presc_sel) - 17'h00001);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			base <= 10'h000;
		end else if (base_tick) begin
			base <= 10'h000;
		end else begin
			base <= base + 10'h001;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			presc <= 17'h00000;
		end else if (tick) begin
			presc <= 17'h00000;
		end else if (base_tick) begin
			presc <= presc + 17'h00001;
		end
	end

	// down count at prescaler rate
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tif.count <= 16'h0000;
		end else if (tif.load) begin
			tif.count <= tif.reload;
		end else if (tif.enable && tick) begin
			if (tif.count == 16'h0000) begin
				tif.count <= tif.reload;
			end else begin
				tif.count <= tif.count - 16'h0001; // RULE_17
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tif.timeout <= 1'b0;
		end else begin
			tif.timeout <= tif.enable && tick && !tif.load &&
				tif.count == 16'h0001; // RULE_17
		end
	end

	assign tif.live = tif.enable && (tif.count == 16'h0000);

	a_timeout_at_zero: assert property (@(posedge ref_clk) disable iff (rst)
		tif.timeout |-> tif.count == 16'h0000 && $past(tif.count) == 16'h0001
	) else $error("timeout without count reaching zero"); // RULE_17

	a_timeout_single: assert property (@(posedge ref_clk) disable iff (rst)
		tif.timeout |=> !tif.timeout
	) else $error("timeout pulse longer than one cycle"); // RULE_17
endmodule

// ==== core/wsr_regs.sv ====
// Purpose: wake-up status, signal strength, AFC limit, image-cal
//          source and shutdown registers
// Assumes: register port on ref_clk; analog status and chip select
//          asynchronous, event inputs on ref_clk
// Notes: read data appear one cycle after the read strobe only
`timescale 1ns/1ns
module wsr_regs
	import wsr_pkg::*;
(
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              rst,
	// register port
	input wire wsr_pkg::wsr_addr_t reg_addr,
	input wire wsr_pkg::wsr_byte_t reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	output wsr_pkg::wsr_byte_t     reg_rdata,
	// asynchronous status inputs
	input wire logic              rc_cal_done_in,
	input wire logic              rc_cal_error_in,
	input wire logic              crystal_settled_in,
	input wire logic              crystal_live_level,
	input wire logic              chip_select,
	// processor events
	input wire logic              cold_start_evt,
	input wire logic              packet_done,
	input wire wsr_pkg::wsr_byte_t rssi_meas,
	input wire logic              rx_entry,
	input wire logic [8:0]        if_bw_khz,
	// control outputs
	output logic                  rc_cal_enable,
	output logic                  crystal_enable,
	output logic                  image_cal_overwrite_en,
	output logic [4:0]            ir_src_divisor,
	output logic [2:0]            ir_power_mult,
	output logic                  shutdown_start,
	output logic                  irq
);
	import wsr_pkg::*;

	wsr_timer_if tif ();

	logic [4:0]      sync_a;
	logic [4:0]      sync_b;
	logic [4:0]      sync_c;
	logic            cal_done_s;
	logic            cal_err_s;
	logic            settled_s;
	logic            level_s;
	logic            cs_s;

	logic            flag_clear_ctrl;
	logic            timeout_sticky_flag;
	logic            cold_start_flag;
	wsr_byte_t       signal_strength_readback;
	wsr_byte_t       afc_pull_in_limit;
	logic [5:0]      image_cal_source_config;
	logic            shutdown_request;
	logic            shut_cond_q;
	logic [15:0]     tmr_reload;
	logic            tmr_enable;
	logic [2:0]      tmr_presc;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_w1c;

	wsr_byte_t       wakeup_status;
	wsr_byte_t       next_rdata;
	logic            shut_cond;

	function automatic logic wr_at(input wsr_addr_t a);
		wr_at = reg_wr && (reg_addr == a);
	endfunction

	// two-stage synchronisers, stage a read only by stage b
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_a <= 5'h00;
			sync_b <= 5'h00;
			sync_c <= 5'h00;
		end else begin
			sync_a <= {chip_select, crystal_live_level,
				crystal_settled_in, rc_cal_error_in, rc_cal_done_in};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	assign cal_done_s = sync_b[0];
	assign cal_err_s  = sync_b[1];
	assign settled_s  = sync_b[2];
	assign level_s    = sync_b[3];
	assign cs_s       = sync_b[4];

	// status word; validity bits gated by their enables
	always_comb begin
		wakeup_status = BYTE_ZERO; // RULE_18
		wakeup_status[ST_CAL_ERR]  = cal_err_s && rc_cal_enable; // RULE_01
		wakeup_status[ST_CAL_DONE] = cal_done_s && rc_cal_enable; // RULE_02
		wakeup_status[ST_XTAL_RDY] = settled_s && crystal_enable; // RULE_03
		wakeup_status[ST_XTAL_LVL] = level_s; // RULE_04
		wakeup_status[ST_COLD]     = cold_start_flag; // RULE_05
		wakeup_status[ST_TO_FLAG]  = timeout_sticky_flag; // RULE_06
		wakeup_status[ST_TO_LIVE]  = tif.live; // RULE_07
	end

	// flag clear control and calibration enable
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flag_clear_ctrl <= 1'b0;
			rc_cal_enable   <= 1'b0;
		end else if (wr_at(ADR_FLAG_CTRL)) begin
			flag_clear_ctrl <= reg_wdata[FC_CLEAR];
			rc_cal_enable   <= reg_wdata[FC_CAL_EN];
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timeout_sticky_flag <= 1'b0;
			cold_start_flag     <= 1'b0;
		end else begin
			if (tif.timeout) begin
				timeout_sticky_flag <= 1'b1; // RULE_06
			end else if (flag_clear_ctrl) begin
				timeout_sticky_flag <= 1'b0; // RULE_16
			end
			if (cold_start_evt) begin
				cold_start_flag <= 1'b1; // RULE_05
			end else if (flag_clear_ctrl) begin
				cold_start_flag <= 1'b0; // RULE_16
			end
		end
	end

	// signal strength: only a finished packet updates it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			signal_strength_readback <= BYTE_ZERO;
		end else if (packet_done) begin
			signal_strength_readback <= rssi_meas; // RULE_08
		end
	end

	// receive entry overrides a same-cycle software write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			afc_pull_in_limit <= AFC_RESET; // RULE_10
		end else if (rx_entry) begin
			afc_pull_in_limit <= if_bw_khz[8:1]; // RULE_11
		end else if (wr_at(ADR_AFC)) begin
			afc_pull_in_limit <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			image_cal_source_config <= 6'h00;
		end else if (wr_at(ADR_IMG_CAL)) begin
			image_cal_source_config <= reg_wdata[5:0];
		end
	end

	// decoded calibration source controls
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			image_cal_overwrite_en <= 1'b0;
			ir_src_divisor         <= 5'h00;
			ir_power_mult          <= 3'h0;
		end else begin
			image_cal_overwrite_en <=
				image_cal_source_config[IMG_OVWRT]; // RULE_12
			unique case (image_cal_source_config[IMG_FREQ_LO +: 2])
				2'h0: ir_src_divisor <= 5'h00; // RULE_13
				2'h1: ir_src_divisor <= 5'h04;
				2'h2: ir_src_divisor <= 5'h08;
				2'h3: ir_src_divisor <= 5'h10;
			endcase
			// codes 1 to 6 share a level in pairs; codes 0 and 7 each have their own
			ir_power_mult <= 3'((4'(image_cal_source_config[IMG_PWR_LO +: 3])
				+ 4'h1) >> 1); // RULE_14
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shutdown_request <= 1'b0;
		end else if (wr_at(ADR_SHUTDOWN)) begin
			shutdown_request <= reg_wdata[SHUT_REQ];
		end
	end

	// one pulse per rise of request-and-select
	assign shut_cond = shutdown_request && cs_s; // RULE_15

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shut_cond_q    <= 1'b0;
			shutdown_start <= 1'b0;
		end else begin
			shut_cond_q    <= shut_cond;
			shutdown_start <= shut_cond && !shut_cond_q; // RULE_15
		end
	end

	// timer control; a low byte write loads both bytes into the counter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tmr_reload     <= 16'h0000;
			tmr_enable     <= 1'b0;
			crystal_enable <= 1'b0;
			tmr_presc      <= 3'h0;
		end else begin
			if (wr_at(ADR_TMR_LO)) begin
				tmr_reload[7:0] <= reg_wdata;
			end
			if (wr_at(ADR_TMR_HI)) begin
				tmr_reload[15:8] <= reg_wdata;
			end
			if (wr_at(ADR_TMR_CTRL)) begin
				tmr_enable     <= reg_wdata[TC_ENABLE];
				crystal_enable <= reg_wdata[TC_XTAL_EN];
				tmr_presc      <= reg_wdata[TC_PRESC_LO +: 3];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tif.load <= 1'b0;
		end else begin
			tif.load <= wr_at(ADR_TMR_LO);
		end
	end

	assign tif.enable    = tmr_enable;
	assign tif.reload    = tmr_reload;
	assign tif.presc_sel = tmr_presc;

	wsr_wakeup_timer u_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.tif     (tif.tmr)
	);

	// interrupt status, write one to clear, set wins
	always_comb begin
		irq_events = '0;
		irq_events[IRQ_TIMEOUT]  = tif.timeout;
		irq_events[IRQ_PACKET]   = packet_done;
		irq_events[IRQ_CAL_DONE] = cal_done_s && !sync_c[0];
		irq_events[IRQ_XTAL_RDY] = settled_s && !sync_c[2];
		irq_w1c = wr_at(ADR_IRQ_STAT) ? reg_wdata[IRQ_W-1:0] : '0;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_status <= '0;
			irq_mask   <= '0;
			irq        <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~irq_w1c) | irq_events;
			if (wr_at(ADR_IRQ_MASK)) begin
				irq_mask <= reg_wdata[IRQ_W-1:0];
			end
			irq <= |(irq_status & irq_mask);
		end
	end

	// read path; unmapped and reserved read zero
	always_comb begin
		next_rdata = BYTE_ZERO;
		unique case (reg_addr)
			ADR_FLAG_CTRL: begin
				next_rdata[FC_CLEAR]  = flag_clear_ctrl;
				next_rdata[FC_CAL_EN] = rc_cal_enable;
			end
			ADR_STATUS:   next_rdata = wakeup_status;
			ADR_RSSI:     next_rdata = signal_strength_readback;
			ADR_AFC:      next_rdata = afc_pull_in_limit;
			ADR_IMG_CAL:  next_rdata = {2'b00, image_cal_source_config};
			ADR_SHUTDOWN: next_rdata[SHUT_REQ] = shutdown_request;
			ADR_TMR_LO:   next_rdata = tmr_reload[7:0];
			ADR_TMR_HI:   next_rdata = tmr_reload[15:8];
			ADR_TMR_CTRL: begin
				next_rdata[TC_ENABLE]        = tmr_enable;
				next_rdata[TC_XTAL_EN]       = crystal_enable;
				next_rdata[TC_PRESC_LO +: 3] = tmr_presc;
			end
			ADR_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_status;
			ADR_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
			default:      next_rdata = BYTE_ZERO; // RULE_18
		endcase
	end

	// data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= BYTE_ZERO;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : BYTE_ZERO;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_cal_error_read: assert property (
		reg_rd && reg_addr == ADR_STATUS
		|=> reg_rdata[ST_CAL_ERR] == $past(cal_err_s && rc_cal_enable)
	) else $error("calibration error bit wrong"); // RULE_01

	a_cal_done_read: assert property (
		reg_rd && reg_addr == ADR_STATUS && !rc_cal_enable
		|=> !reg_rdata[ST_CAL_DONE]
	) else $error("calibration done shown while disabled"); // RULE_02

	a_settled_read: assert property (
		reg_rd && reg_addr == ADR_STATUS
		|=> reg_rdata[ST_XTAL_RDY] == $past(settled_s && crystal_enable)
	) else $error("crystal settled bit wrong"); // RULE_03

	a_live_zero: assert property (
		reg_rd && reg_addr == ADR_STATUS
		|=> reg_rdata[ST_TO_LIVE] == $past(tif.count == 16'h0000 && tmr_enable)
	) else $error("live timeout bit not tied to zero count"); // RULE_07

	a_sticky_hold: assert property (
		timeout_sticky_flag && !flag_clear_ctrl |=> timeout_sticky_flag
	) else $error("timeout flag lost without clear"); // RULE_06

	a_sticky_set: assert property (
		tif.timeout |=> timeout_sticky_flag
	) else $error("timeout not latched"); // RULE_06

	a_flags_clear: assert property (
		flag_clear_ctrl && !tif.timeout && !cold_start_evt
		|=> !timeout_sticky_flag && !cold_start_flag
	) else $error("flag clear did not clear flags"); // RULE_16

	a_cold_set: assert property (
		cold_start_evt |=> cold_start_flag
	) else $error("cold start not recorded"); // RULE_05

	a_rssi_latch: assert property (
		packet_done |=> signal_strength_readback == $past(rssi_meas)
	) else $error("strength not captured on packet"); // RULE_08

	a_rssi_ro: assert property (
		reg_wr && reg_addr == ADR_RSSI && !packet_done
		|=> $stable(signal_strength_readback)
	) else $error("write changed read-only strength"); // RULE_18

	a_afc_reload: assert property (
		rx_entry |=> afc_pull_in_limit == $past(if_bw_khz[8:1])
	) else $error("pull-in limit not half bandwidth"); // RULE_11

	a_afc_keep: assert property (
		!rx_entry && !(reg_wr && reg_addr == ADR_AFC)
		|=> $stable(afc_pull_in_limit)
	) else $error("pull-in limit changed on its own"); // RULE_10

	a_power_map: assert property (
		image_cal_source_config[IMG_PWR_LO +: 3] == 3'h7
		|=> ir_power_mult == 3'h4
	) else $error("top power code not four times"); // RULE_14

	a_shutdown_gate: assert property (
		shutdown_start |-> $past(shutdown_request) && $past(cs_s)
	) else $error("shutdown without request and select"); // RULE_15

	a_irq_level: assert property (
		##1 irq == |($past(irq_status) & $past(irq_mask))
	) else $error("interrupt output mismatch");
endmodule

// ==== testbench/wsr_regs_tb.sv ====
// Purpose: self-checking bench for the wake-up status register bank
// Assumes: default timer base tick, prescaler select 0
// Notes: only mismatches and the verdict are printed
`timescale 1ns/1ns
module wsr_regs_tb;
	import wsr_pkg::*;

	logic      ref_clk;
	logic      rst;
	wsr_addr_t reg_addr;
	wsr_byte_t reg_wdata;
	logic      reg_wr;
	logic      reg_rd;
	wsr_byte_t reg_rdata;
	logic      rc_cal_done_in;
	logic      rc_cal_error_in;
	logic      crystal_settled_in;
	logic      crystal_live_level;
	logic      chip_select;
	logic      cold_start_evt;
	logic      packet_done;
	wsr_byte_t rssi_meas;
	logic      rx_entry;
	logic [8:0] if_bw_khz;
	logic      rc_cal_enable;
	logic      crystal_enable;
	logic      image_cal_overwrite_en;
	logic [4:0] ir_src_divisor;
	logic [2:0] ir_power_mult;
	logic      shutdown_start;
	logic      irq;
	int        num_errors;
	int        cmp_count;
	wsr_byte_t d;
	wsr_byte_t wd;
	logic [2:0] k;
	int        n;
	logic [4:0] divs [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
	logic [2:0] mults [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};

	wsr_regs uut (
		.ref_clk                (ref_clk),
		.rst                    (rst),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.rc_cal_done_in         (rc_cal_done_in),
		.rc_cal_error_in        (rc_cal_error_in),
		.crystal_settled_in     (crystal_settled_in),
		.crystal_live_level     (crystal_live_level),
		.chip_select            (chip_select),
		.cold_start_evt         (cold_start_evt),
		.packet_done            (packet_done),
		.rssi_meas              (rssi_meas),
		.rx_entry               (rx_entry),
		.if_bw_khz              (if_bw_khz),
		.rc_cal_enable          (rc_cal_enable),
		.crystal_enable         (crystal_enable),
		.image_cal_overwrite_en (image_cal_overwrite_en),
		.ir_src_divisor         (ir_src_divisor),
		.ir_power_mult          (ir_power_mult),
		.shutdown_start         (shutdown_start),
		.irq                    (irq)
	);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic summarize;
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
		input string msg);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t %s seen %h exp %h", $time, msg,
				seen, exp);
		end
	endtask

	task automatic wr(input wsr_addr_t a, input wsr_byte_t v);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input wsr_addr_t a, output wsr_byte_t v);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		v = reg_rdata;
	endtask

	task automatic cycles(input int c);
		repeat (c) @(posedge ref_clk);
	endtask

	task automatic count_shut(input int c, output int cnt);
		cnt = 0;
		repeat (c) begin
			@(negedge ref_clk);
			if (shutdown_start === 1'b1)
				cnt++;
		end
	endtask

	initial begin
		num_errors = 0;
		cmp_count = 0;
		rst = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rc_cal_done_in = 1'b0;
		rc_cal_error_in = 1'b0;
		crystal_settled_in = 1'b0;
		crystal_live_level = 1'b0;
		chip_select = 1'b0;
		cold_start_evt = 1'b0;
		packet_done = 1'b0;
		rssi_meas = '0;
		rx_entry = 1'b0;
		if_bw_khz = '0;
		cycles(16);
		rst <= 1'b0;
		// reset values and an unmapped hole
		rd(ADR_AFC, d);    check(d, AFC_RESET, "afc reset");
		rd(ADR_STATUS, d); check(d, BYTE_ZERO, "status reset");
		rd(ADR_RSSI, d);   check(d, BYTE_ZERO, "rssi reset");
		rd(10'h3FF, d);    check(d, BYTE_ZERO, "unmapped read");
		// every frequency and power code, reserved bits written high
		for (int i = 0; i < 8; i++) begin
			k = i[2:0];
			wd = {2'b11, k[0], k[1:0], k};
			wr(ADR_IMG_CAL, wd);
			cycles(2);
			@(negedge ref_clk);
			check(8'(image_cal_overwrite_en), 8'(k[0]), "ovw");
			check(8'(ir_src_divisor), 8'(divs[k[1:0]]), "freq");
			check(8'(ir_power_mult), 8'(mults[k]), "power");
			rd(ADR_IMG_CAL, d); check(d, wd & 8'h3F, "img rb");
		end
		// strength capture; writes to read-only places ignored
		@(posedge ref_clk);
		packet_done <= 1'b1;
		rssi_meas   <= 8'hA5;
		@(posedge ref_clk);
		packet_done <= 1'b0;
		rssi_meas   <= 8'h5A;
		wr(ADR_RSSI, 8'h00);
		wr(ADR_STATUS, 8'hFF);
		rd(ADR_RSSI, d);   check(d, 8'hA5, "rssi");
		check(d - 8'h6B, 8'h3A, "rssi dbm");
		rd(ADR_STATUS, d); check(d, BYTE_ZERO, "status ro");
		check(8'(irq), 8'h00, "masked irq");
		// pull-in limit: written, then reloaded on receive entry
		wr(ADR_AFC, 8'h11);
		rd(ADR_AFC, d); check(d, 8'h11, "afc rw");
		@(posedge ref_clk);
		rx_entry  <= 1'b1;
		if_bw_khz <= 9'h0C8;
		@(posedge ref_clk);
		rx_entry <= 1'b0;
		rd(ADR_AFC, d); check(d, 8'h64, "afc 200k");
		@(posedge ref_clk);
		rx_entry  <= 1'b1;
		if_bw_khz <= 9'h12D;
		@(posedge ref_clk);
		rx_entry <= 1'b0;
		rd(ADR_AFC, d); check(d, 8'h96, "afc 301k");
		// analog status with their enables on
		wr(ADR_FLAG_CTRL, 8'h02);
		wr(ADR_TMR_CTRL, 8'h02);
		rc_cal_done_in     <= 1'b1;
		rc_cal_error_in    <= 1'b1;
		crystal_settled_in <= 1'b1;
		crystal_live_level <= 1'b1;
		cycles(4);
		@(negedge ref_clk);
		check(8'({rc_cal_enable, crystal_enable}), 8'h03, "enables");
		rd(ADR_STATUS, d);
		check(d & 8'hF8, 8'h78, "analog");
		crystal_live_level <= 1'b0;
		rc_cal_error_in    <= 1'b0;
		cycles(4);
		rd(ADR_STATUS, d); check(d & 8'h58, 8'h10, "level");
		// cold start record
		@(posedge ref_clk);
		cold_start_evt <= 1'b1;
		@(posedge ref_clk);
		cold_start_evt <= 1'b0;
		rd(ADR_STATUS, d); check(d & 8'h04, 8'h04, "cold");
		// timer reload 2, high byte first, timeout unmasked
		wr(ADR_IRQ_STAT, 8'h0F);
		wr(ADR_IRQ_MASK, 8'h01);
		wr(ADR_TMR_HI, 8'h00);
		wr(ADR_TMR_LO, 8'h02);
		wr(ADR_TMR_CTRL, 8'h03);
		n = 0;
		while (irq !== 1'b1) begin
			@(posedge ref_clk);
			n++;
			if (n > 3000) begin
				num_errors++;
				summarize();
			end
		end
		// first tick anywhere in one base period, second a full one later
		check(8'(n > TICK_CYCLES && n <= 2 * TICK_CYCLES + 4),
			8'h01, "timeout window");
		rd(ADR_STATUS, d);
		check(d & 8'h03, 8'h03, "at zero");
		wr(ADR_TMR_CTRL, 8'h02);
		cycles(2);
		rd(ADR_STATUS, d); check(d & 8'h03, 8'h02, "sticky");
		rd(ADR_IRQ_STAT, d); check(d & 8'h01, 8'h01, "irq stat");
		wr(ADR_IRQ_STAT, 8'h01);
		cycles(3);
		@(negedge ref_clk);
		check(8'(irq), 8'h00, "irq cleared");
		// flag clear drops timeout and cold flags together
		wr(ADR_FLAG_CTRL, 8'h03);
		wr(ADR_FLAG_CTRL, 8'h02);
		rd(ADR_STATUS, d); check(d & 8'h06, 8'h00, "flag clear");
		// shutdown only with chip select high
		wr(ADR_SHUTDOWN, 8'h01);
		count_shut(8, n); check(8'(n), 8'h00, "no cs");
		@(posedge ref_clk);
		chip_select <= 1'b1;
		count_shut(8, n); check(8'(n), 8'h01, "one pulse");
		rd(ADR_SHUTDOWN, d); check(d, 8'h01, "shut rb");
		wr(ADR_SHUTDOWN, 8'hFE);
		rd(ADR_SHUTDOWN, d); check(d, 8'h00, "shut rsvd");
		chip_select <= 1'b0;
		summarize();
	end
endmodule
